// *** wwd_pkg.sv ***
package wwd_pkg;

  // counter and divider geometry
  localparam int WWD_CNT_W = 24;
  localparam int WWD_DIV_W = 8;
  localparam int WWD_PRESCALE = 4;
  localparam int WWD_AW = 6;
  localparam int WWD_NST = 4;

  // register byte offsets
  localparam logic [5:0] WWD_CTRL_OFS = 6'h00;
  localparam logic [5:0] WWD_RELOAD_OFS = 6'h04;
  localparam logic [5:0] WWD_FEED_OFS = 6'h08;
  localparam logic [5:0] WWD_COUNT_OFS = 6'h0c;
  localparam logic [5:0] WWD_WARN_OFS = 6'h10;
  localparam logic [5:0] WWD_WINDOW_OFS = 6'h14;
  localparam logic [5:0] WWD_DIV_OFS = 6'h18;
  localparam logic [5:0] WWD_STAT_OFS = 6'h1c;
  localparam logic [5:0] WWD_CLR_OFS = 6'h20;
  localparam logic [5:0] WWD_IEN_OFS = 6'h24;

  // control bit positions
  localparam int WWD_CTRL_EN = 0;
  localparam int WWD_CTRL_RSTSEL = 1;
  localparam int WWD_CTRL_PROT = 2;
  localparam int WWD_CTRL_SLEEP = 3;

  // status, clear and enable bit positions
  localparam int WWD_ST_TOUT = 0;
  localparam int WWD_ST_WARN = 1;
  localparam int WWD_ST_EARLY = 2;
  localparam int WWD_ST_WDRST = 3;

  // reset values and limits
  localparam logic [23:0] WWD_RELOAD_RST = 24'hffffff;
  localparam logic [23:0] WWD_RELOAD_MIN = 24'h0000ff;
  localparam logic [23:0] WWD_WARN_RST = 24'h000000;
  localparam logic [23:0] WWD_WINDOW_RST = 24'hffffff;
  localparam logic [7:0] WWD_DIV_RST = 8'h00;

  // feed keys
  localparam logic [7:0] WWD_FEED_KEY1 = 8'haa;
  localparam logic [7:0] WWD_FEED_KEY2 = 8'h55;

  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [31:0] writedata;
  } wwd_bus_req_type;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } wwd_bus_rsp_type;

endpackage : wwd_pkg

// *** wwd_tick.sv ***
module wwd_tick #(
  parameter int DIV_W = 8
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic osc_i,
  input wire logic [DIV_W-1:0] div_i,
  input wire logic run_i,
  output logic cnt_tick_o
);
  import wwd_pkg::*;

  initial begin
    if (DIV_W < 1 || DIV_W > 16) begin
      $error("wwd_tick: DIV_W out of range");
    end
  end

  typedef struct packed {
    logic [1:0] sync;
    logic last;
    logic [DIV_W-1:0] div_cnt;
    logic [1:0] pre_cnt;
    logic tick;
  } wwd_tick_st_type;

  wwd_tick_st_type s_q, s_d;
  logic osc_edge;
  logic wd_tick;

  always_comb begin
    s_d = s_q;
    s_d.sync = {s_q.sync[0], osc_i};
    s_d.last = s_q.sync[1];
    osc_edge = s_q.sync[1] & ~s_q.last;
    wd_tick = osc_edge && (s_q.div_cnt == div_i);
    s_d.tick = 1'b0;
    if (osc_edge) begin
      s_d.div_cnt = wd_tick ? '0 : s_q.div_cnt + 1'b1;
    end
    if (!run_i) begin
      s_d.pre_cnt = '0;
    end else if (wd_tick) begin
      // fixed divide by four ahead of the counter
      s_d.pre_cnt = s_q.pre_cnt + 2'h1;
      s_d.tick = (s_q.pre_cnt == 2'(WWD_PRESCALE - 1));
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cnt_tick_o = s_q.tick;

endmodule : wwd_tick

// *** wwd_top.sv ***
// The implementer's own choices: the register addresses and register access over Avalon-MM.
module wwd_top (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic osc_i,
  input wire logic deep_sleep_i,
  input wire logic dbg_halt_i,
  input wire wwd_pkg::wwd_bus_req_type bus_i,
  output wwd_pkg::wwd_bus_rsp_type bus_o,
  output logic irq_o,
  output logic chip_reset_o
);
  import wwd_pkg::*;

  typedef struct packed {
    logic en;
    logic rst_sel;
    logic prot;
    logic sleep_run;
    logic [23:0] reload;
    logic [23:0] warn;
    logic [23:0] window;
    logic [23:0] count;
    logic [7:0] div;
    logic [3:0] stat;
    logic [3:0] ien;
    logic armed;
    logic wreq;
    logic [31:0] rdata;
    logic irq;
    logic chip_rst;
  } wwd_state_type;

  wwd_state_type s_q, s_d;
  logic cnt_tick, run, tick, req, acc, wr;
  logic feed_wr, good1, good2, bad, feed, early, tout, warn_hit, prot_ok, evt;
  logic [23:0] dec, wdata24;

  function automatic logic [31:0] rd_mux(input wwd_state_type s, input logic [5:0] a);
    logic [31:0] v;
    v = '0;
    unique case (a)
      WWD_CTRL_OFS: v = {28'h0000000, s.sleep_run, s.prot, s.rst_sel, s.en};
      WWD_RELOAD_OFS: v = {8'h00, s.reload};
      WWD_COUNT_OFS: v = {8'h00, s.count};
      WWD_WARN_OFS: v = {8'h00, s.warn};
      WWD_WINDOW_OFS: v = {8'h00, s.window};
      WWD_DIV_OFS: v = {24'h000000, s.div};
      WWD_STAT_OFS: v = {28'h0000000, s.stat};
      WWD_IEN_OFS: v = {28'h0000000, s.ien};
      default: v = '0;
    endcase
    return v;
  endfunction : rd_mux

  // counting stops in debug halt and in deep-sleep unless told to run
  // sleep run gate
  assign run = s_q.en & ~dbg_halt_i & (~deep_sleep_i | s_q.sleep_run);

  wwd_tick #(
    .DIV_W(WWD_DIV_W)
  ) u_tick (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .osc_i(osc_i),
    .div_i(s_q.div),
    .run_i(run),
    .cnt_tick_o(cnt_tick)
  );

  always_comb begin
    s_d = s_q;
    s_d.chip_rst = 1'b0;
    tick = cnt_tick & run;
    req = bus_i.read | bus_i.write;
    // one wait state: the access completes in the cycle waitrequest is low
    acc = req & ~s_q.wreq;
    wr = acc & bus_i.write;
    s_d.wreq = ~(req & s_q.wreq);
    if (req & s_q.wreq) begin
      s_d.rdata = rd_mux(s_q, bus_i.address);
    end
    wdata24 = bus_i.writedata[23:0];
    dec = s_q.count - 24'h000001;

    feed_wr = wr && (bus_i.address == WWD_FEED_OFS);
    good1 = feed_wr && (bus_i.writedata[7:0] == WWD_FEED_KEY1);
    good2 = feed_wr && s_q.armed && (bus_i.writedata[7:0] == WWD_FEED_KEY2);
    bad = acc && ((feed_wr && !good1 && !good2) || (!feed_wr && s_q.armed));
    if (acc) begin
      s_d.armed = good1;
    end
    feed = good2;

    early = feed && s_q.en && (s_q.count > s_q.window);
    tout = s_q.en && tick && (s_q.count == '0);
    warn_hit = s_q.en && tick && (s_q.count != '0) && (dec == s_q.warn);
    prot_ok = ~s_q.prot | (s_q.count <= s_q.warn);
    evt = tout | early | (s_q.en & bad);

    if (!s_q.en) begin
      s_d.count = s_q.reload;
    end else if (feed) begin
      s_d.count = s_q.reload;
    end else if (tick && (s_q.count != '0)) begin
      s_d.count = dec;
    end

    if (wr) begin
      unique case (bus_i.address)
        WWD_CTRL_OFS: begin
          s_d.en = s_q.en | bus_i.writedata[WWD_CTRL_EN];
          s_d.rst_sel = s_q.rst_sel | bus_i.writedata[WWD_CTRL_RSTSEL];
          s_d.prot = s_q.prot | bus_i.writedata[WWD_CTRL_PROT];
          s_d.sleep_run = bus_i.writedata[WWD_CTRL_SLEEP];
          if (!s_q.en) begin
            s_d.count = s_q.reload;
          end
        end
        WWD_RELOAD_OFS: begin
          if (prot_ok) begin
            s_d.reload = (wdata24 < WWD_RELOAD_MIN) ? WWD_RELOAD_MIN : wdata24;
          end
        end
        WWD_WARN_OFS: s_d.warn = wdata24;
        WWD_WINDOW_OFS: s_d.window = wdata24;
        WWD_DIV_OFS: s_d.div = bus_i.writedata[7:0];
        WWD_CLR_OFS: s_d.stat = s_q.stat & ~bus_i.writedata[3:0];
        WWD_IEN_OFS: s_d.ien = bus_i.writedata[3:0];
        default: s_d.ien = s_q.ien;
      endcase
    end

    // sets are applied after the clear so a coincident event is kept
    if (warn_hit) begin
      s_d.stat[WWD_ST_WARN] = 1'b1;
    end
    if (evt) begin
      s_d.count = s_q.reload;
      s_d.armed = 1'b0;
      if (s_q.rst_sel) begin
        s_d.chip_rst = 1'b1;
        s_d.stat[WWD_ST_WDRST] = 1'b1;
        s_d.en = 1'b0;
        s_d.rst_sel = 1'b0;
        s_d.prot = 1'b0;
        s_d.sleep_run = 1'b0;
      end else begin
        s_d.stat[WWD_ST_TOUT] = s_d.stat[WWD_ST_TOUT] | tout;
        s_d.stat[WWD_ST_EARLY] = s_d.stat[WWD_ST_EARLY] | ~tout;
      end
    end
    s_d.irq = |(s_d.stat & s_d.ien);
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
      s_q.wreq <= 1'b1;
      s_q.reload <= WWD_RELOAD_RST;
      s_q.count <= WWD_RELOAD_RST;
      s_q.warn <= WWD_WARN_RST;
      s_q.window <= WWD_WINDOW_RST;
      s_q.div <= WWD_DIV_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_o.readdata = s_q.rdata;
  assign bus_o.waitrequest = s_q.wreq;
  assign irq_o = s_q.irq;
  assign chip_reset_o = s_q.chip_rst;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  property p_timeout_act;
    s_q.en && tick && (s_q.count == '0)
      |=> (s_q.chip_rst || s_q.stat[WWD_ST_TOUT]);
  endproperty
  a_timeout_act: assert property (p_timeout_act) else $error("time-out without action");

  property p_chip_rst;
    chip_reset_o |-> (s_q.stat[WWD_ST_WDRST] && !s_q.en && !s_q.rst_sel);
  endproperty
  a_chip_rst: assert property (p_chip_rst) else $error("chip reset without flag");

  property p_early;
    feed && s_q.en && (s_q.count > s_q.window)
      |=> (s_q.chip_rst || s_q.stat[WWD_ST_EARLY]) && (s_q.count == s_q.reload);
  endproperty
  a_early: assert property (p_early) else $error("early feed not punished");

  property p_warn;
    warn_hit |=> s_q.stat[WWD_ST_WARN] ##1 s_q.stat[WWD_ST_WARN] || s_q.chip_rst || $past(wr);
  endproperty
  a_warn: assert property (p_warn) else $error("warning flag missed");

  property p_dec;
    s_q.en && tick && (s_q.count != '0) && !acc && !evt
      |=> s_q.count == $past(s_q.count) - 24'h000001;
  endproperty
  a_dec: assert property (p_dec) else $error("counter did not step by one");

  property p_min;
    s_q.reload >= WWD_RELOAD_MIN;
  endproperty
  a_min: assert property (p_min) else $error("reload below shortest period");

  property p_no_disable;
    $fell(s_q.en) |-> s_q.chip_rst;
  endproperty
  a_no_disable: assert property (p_no_disable) else $error("watchdog disabled by software");

  property p_bad_feed;
    s_q.en && bad |=> s_q.chip_rst || (s_q.stat[WWD_ST_EARLY] && !s_q.armed);
  endproperty
  a_bad_feed: assert property (p_bad_feed) else $error("wrong feed ignored");

  property p_lock;
    wr && (bus_i.address == WWD_RELOAD_OFS) && s_q.prot && (s_q.count > s_q.warn)
      |=> $stable(s_q.reload);
  endproperty
  a_lock: assert property (p_lock) else $error("locked reload changed");

  property p_flag;
    $rose(s_q.stat[WWD_ST_WDRST]) |-> chip_reset_o;
  endproperty
  a_flag: assert property (p_flag) else $error("reset flag without reset");

  property p_tick_gap;
    cnt_tick |=> !cnt_tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("count ticks too close");

  property p_sleep_hold;
    s_q.en && deep_sleep_i && !s_q.sleep_run && !acc && !evt |=> $stable(s_q.count);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("counted in deep-sleep");

  property p_window_ok;
    feed && s_q.en && (s_q.count <= s_q.window) && !tout |=> s_q.count == s_q.reload && !s_q.chip_rst;
  endproperty
  a_window_ok: assert property (p_window_ok) else $error("good feed refused");

  c_good_feed: cover property (feed && s_q.en && !early);
  c_chip_rst: cover property (chip_reset_o);
  c_irq: cover property ($rose(irq_o));
  c_warn: cover property (warn_hit);

endmodule : wwd_top

// *** wwd_top_tb_top.sv ***
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_errors++; $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module wwd_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import wwd_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic osc_i = 1'b0;
  logic deep_sleep_i = 1'b0;
  logic dbg_halt_i = 1'b0;
  wwd_bus_req_type bus_i = '0;
  wwd_bus_rsp_type bus_o;
  logic irq_o;
  logic chip_reset_o;
  logic saw_rst = 1'b0;
  logic [4:0] osc_cnt_q = 5'h00;
  logic [31:0] t;
  logic [31:0] bus_rd;
  int n_errors = 0;
  int n_compared = 0;
  int k;
  realtime t0;

  always #12.5 clk_i = ~clk_i;

  // slow oscillator: 40 clock periods, i.e. 1 MHz
  always @(posedge clk_i) begin
    osc_cnt_q <= osc_cnt_q + 5'h01;
    if (osc_cnt_q == 5'h13) begin
      osc_cnt_q <= 5'h00;
      osc_i <= ~osc_i;
    end
  end

  always @(posedge clk_i) begin
    if (chip_reset_o === 1'b1) saw_rst <= 1'b1;
  end

  wwd_top dut (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .osc_i(osc_i),
    .deep_sleep_i(deep_sleep_i),
    .dbg_halt_i(dbg_halt_i),
    .bus_i(bus_i),
    .bus_o(bus_o),
    .irq_o(irq_o),
    .chip_reset_o(chip_reset_o)
  );

  // one access; held until the edge at which waitrequest is seen low
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    bus_i <= '{read: ~w, write: w, address: a, writedata: d};
    // waitrequest and read data are taken at the same rising edge
    do begin
      @(posedge clk_i);
      n++;
    end while (bus_o.waitrequest !== 1'b0 && n < 20);
    r = bus_o.readdata;
    if (n >= 20) n_errors++;
    bus_i <= '0;
  endtask : acc

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    acc(1'b1, a, d, r);
  endtask : wr

  task automatic rc(input logic [5:0] a, input logic [31:0] ex, input string nm);
    logic [31:0] r;
    acc(1'b0, a, 32'h0, r);
    `CHK(nm, ex, r)
  endtask : rc

  task automatic feed();
    wr(WWD_FEED_OFS, 32'h000000aa);
    wr(WWD_FEED_OFS, 32'h00000055);
  endtask : feed

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    repeat (90000) @(posedge clk_i);
    n_errors++;
    results();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rc(WWD_CTRL_OFS, 32'h0, "ctrl");
    rc(WWD_RELOAD_OFS, 32'h00ffffff, "reload");
    rc(WWD_STAT_OFS, 32'h0, "status");
    rc(6'h3c, 32'h0, "unmapped");
    $display("test reset values done");
    wr(WWD_RELOAD_OFS, 32'h00000010);
    rc(WWD_RELOAD_OFS, 32'h000000ff, "reload clamp");
    wr(WWD_WARN_OFS, 32'h000000f0);
    $display("test reload clamp done");
    wr(WWD_CTRL_OFS, 32'h1);
    feed();
    rc(WWD_STAT_OFS, 32'h0, "good feed");
    wr(WWD_FEED_OFS, 32'h00000012);
    rc(WWD_STAT_OFS, 32'h4, "wrong feed");
    wr(WWD_IEN_OFS, 32'h4);
    repeat (3) @(posedge clk_i);
    `CHK("irq set", 1'b1, irq_o)
    wr(WWD_CLR_OFS, 32'h4);
    repeat (3) @(posedge clk_i);
    `CHK("irq clear", 1'b0, irq_o)
    $display("test wrong feed done");
    wr(WWD_CTRL_OFS, 32'h0);
    rc(WWD_CTRL_OFS, 32'h1, "no disable");
    $display("test lock done");
    // count runs 0xff down through 0: 256 ticks of 160 clocks
    t0 = $realtime;
    feed();
    k = 0;
    do begin
      acc(1'b0, WWD_STAT_OFS, 32'h0, t);
      k++;
    end while (t[WWD_ST_TOUT] !== 1'b1 && k < 20000);
    `CHK("status tout", 32'h3, t)
    `CHK("period", 1'b1, ($realtime - t0) > 255.0 * 160.0 * 25.0)
    `CHK("period max", 1'b1, ($realtime - t0) < 257.0 * 160.0 * 25.0)
    $display("test time-out done");
    wr(WWD_CLR_OFS, 32'hf);
    wr(WWD_CTRL_OFS, 32'h5);
    wr(WWD_RELOAD_OFS, 32'h000001ff);
    rc(WWD_RELOAD_OFS, 32'h000000ff, "protected");
    $display("test protection done");
    deep_sleep_i <= 1'b1;
    acc(1'b0, WWD_COUNT_OFS, 32'h0, t);
    repeat (400) @(posedge clk_i);
    rc(WWD_COUNT_OFS, t, "sleep hold");
    wr(WWD_CTRL_OFS, 32'hd);
    repeat (400) @(posedge clk_i);
    rc(WWD_CTRL_OFS, 32'hd, "sleep run ctrl");
    acc(1'b0, WWD_COUNT_OFS, 32'h0, bus_rd);
    `CHK("sleep run", 1'b1, (bus_rd < t))
    deep_sleep_i <= 1'b0;
    $display("test deep-sleep done");
    wr(WWD_WINDOW_OFS, 32'h00000080);
    feed();
    rc(WWD_STAT_OFS, 32'h4, "early feed");
    $display("test window done");
    wr(WWD_CLR_OFS, 32'hf);
    wr(WWD_CTRL_OFS, 32'h2);
    wr(WWD_FEED_OFS, 32'h00000033);
    repeat (4) @(posedge clk_i);
    `CHK("chip reset", 1'b1, saw_rst)
    rc(WWD_STAT_OFS, 32'h8, "wd reset flag");
    rc(WWD_CTRL_OFS, 32'h0, "ctrl cleared");
    $display("test chip reset done");
    results();
  end
endmodule : wwd_top_tb_top
